// >>> channel_flag.sv
// Event and overcapture flags of one capture/compare channel
`timescale 1ns/1ps
module channel_flag
    import timer_flags_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic compareMatch,
    input wire logic captureEvent,
    input wire logic isInput,
    input wire logic captureRead,
    input wire logic clearEvent,
    input wire logic clearOver,
    output logic eventFlag,
    output logic overFlag
);

    chan_state_t s;
    chan_state_t next_s;
    logic setEvent;
    logic setOver;

    always_comb begin
        next_s = s;
        setEvent = isInput ? captureEvent : compareMatch;
        setOver = isInput & captureEvent & s.eventFlag;
        next_s.eventFlag = (s.eventFlag & ~(clearEvent | captureRead)) | setEvent;
        next_s.overFlag = (s.overFlag & ~clearOver) | setOver;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign eventFlag = s.eventFlag;
    assign overFlag = s.overFlag;

    property p_capture_sets;
        @(posedge ref_clk) disable iff (!reset_n)
        isInput & captureEvent |=> eventFlag;
    endproperty
    a_capture_sets: assert property (p_capture_sets) else $error("capture lost");

    property p_over_sets;
        @(posedge ref_clk) disable iff (!reset_n)
        isInput & captureEvent & eventFlag |=> overFlag;
    endproperty
    a_over_sets: assert property (p_over_sets) else $error("overcapture lost");

    property p_output_no_over;
        @(posedge ref_clk) disable iff (!reset_n)
        !isInput & !overFlag & !clearOver |=> !overFlag;
    endproperty
    a_output_no_over: assert property (p_output_no_over) else $error("overcapture in output");

endmodule

// >>> sticky_flag.sv
// Sticky flag set by hardware, cleared by software, set wins
`timescale 1ns/1ps
module sticky_flag
    import timer_flags_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic setPulse,
    input wire logic clearPulse,
    output logic flag
);

    sticky_state_t s;
    sticky_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.flag = (s.flag & ~clearPulse) | setPulse;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign flag = s.flag;

    property p_set_wins;
        @(posedge ref_clk) disable iff (!reset_n)
        setPulse |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag not set");

endmodule

// >>> testbench.sv
// Self-checking bench of the timer status flag block
`timescale 1ns/1ps
`include "timer_flags_regs.svh"
module testbench
    import timer_flags_pkg::*;
;
    // ==========================================================
    // Signals and expectation queues
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    timer_events_t timerEvents = '0;
    chan_events_t chanEvents = '0;
    logic updateEvent, irq;
    logic [3:0] channelIrq, dmaRequest;
    logic probeReq = 1'h0;
    logic [7:0] updSeen = 8'h0;
    logic [7:0] upd = 8'h0;
    logic [15:0] flg = 16'h0, pend = 16'h0, ctl = 16'h0, ena = 16'h0;
    int errors = 0;
    int checked = 0;
    logic [63:0] expR[$], expB[$], expP[$];

    always #2.5 ref_clk = ~ref_clk;

    timer_status_flags timer_status_flags_i (
        .ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timerEvents,
        .chanEvents, .updateEvent, .irq, .channelIrq, .dmaRequest
    );

    // ==========================================================
    // Comparison, verdict and watchdog
    task automatic cmp(input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end

    // Takes the oldest note whenever a result shows
    always @(posedge ref_clk) begin
        if (updateEvent === 1'h1)
            updSeen++;
        if (s_axi_rvalid && s_axi_rready)
            cmp(expR.pop_front(), {30'h0, s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            cmp(expB.pop_front(), {62'h0, s_axi_bresp});
        if (probeReq)
            cmp(expP.pop_front(), {47'h0, irq, channelIrq, dmaRequest, updSeen});
    end

    // ==========================================================
    // Bus and event drivers with the flag model
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge ref_clk);
        expB.push_back({62'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] r);
        @(posedge ref_clk);
        expR.push_back({30'h0, r, 16'h0, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask

    task automatic ev(input timer_events_t t, input chan_events_t c);
        logic [15:0] s;
        s = 16'h0;
        if ((t.counterOverflow && !ctl[1]) || (t.triggerReinit && ctl[2:1] == 2'h0)) begin
            s[0] = 1'h1;
            upd++;
        end
        s[6] = t.triggerEvent;
        s[4:1] = (c.match & ~c.isInput) | (c.capture & c.isInput);
        s[12:9] = c.capture & c.isInput & flg[4:1];
        flg = (flg & ~{11'h0, c.captureRead, 1'h0}) | s;
        pend = pend | (s & 16'h005f);
        @(posedge ref_clk);
        timerEvents <= t;
        chanEvents <= c;
        @(posedge ref_clk);
        timerEvents <= '0;
        chanEvents <= {8'h0, c.isInput, 4'h0};
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic gen(input logic [31:0] d);
        wr(`OFS_GENERATE, d, `RESP_OKAY);
        if (d[0] && ctl[2:1] == 2'h0) begin
            flg[0] = 1'h1;
            pend[0] = 1'h1;
            upd++;
        end
        if (d[6]) begin
            flg[6] = 1'h1;
            pend[6] = 1'h1;
        end
    endtask

    task automatic chk_clear();
        rd(`OFS_FLAGS, flg, `RESP_OKAY);
        wr(`OFS_FLAGS, 32'h0, `RESP_OKAY);
        flg = 16'h0;
    endtask

    task automatic probe();
        @(posedge ref_clk);
        expP.push_back({47'h0, |(pend & ena & 16'h005f), flg[4:1] & ena[4:1],
                        flg[4:1] & ena[12:9], upd});
        probeReq <= 1'h1;
        @(posedge ref_clk);
        probeReq <= 1'h0;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        int i;
        logic [31:0] w;
        void'($urandom(32'h67c86fff));
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rd(`OFS_FLAGS, `RST_FLAGS, `RESP_OKAY);
        rd(`OFS_CONTROL, `RST_CONTROL, `RESP_OKAY);
        rd(`OFS_ENABLES, `RST_ENABLES, `RESP_OKAY);
        rd(`OFS_PENDING, `RST_PENDING, `RESP_OKAY);
        rd(`OFS_GENERATE, 16'h0, `RESP_OKAY);
        rd(12'h020, 16'h0, `RESP_SLVERR);
        wr(12'h024, 32'hffff, `RESP_SLVERR);
        probe();
        wr(`OFS_ENABLES, 32'h5f5f, `RESP_OKAY);
        ena = 16'h5f5f;
        for (i = 0; i < 4; i++) begin
            ev(3'h0, 16'h0110 << i);
            ev(3'h0, 16'h0110 << i);
            rd(`OFS_FLAGS, flg, `RESP_OKAY);
            probe();
            ev(3'h0, 16'h0011 << i);
            rd(`OFS_FLAGS, flg, `RESP_OKAY);
            ev(3'h0, 16'h1000 << i);
            ev(3'h0, 16'h1000 << i);
            rd(`OFS_FLAGS, flg, `RESP_OKAY);
            probe();
        end
        ev(3'h4, 16'h0);
        ev(3'h1, 16'h0);
        rd(`OFS_FLAGS, flg, `RESP_OKAY);
        wr(`OFS_FLAGS, 32'hffff_ffff, `RESP_OKAY);
        rd(`OFS_FLAGS, flg, `RESP_OKAY);
        repeat (4) begin
            w = $urandom;
            wr(`OFS_FLAGS, w, `RESP_OKAY);
            flg = flg & w[15:0];
            rd(`OFS_FLAGS, flg, `RESP_OKAY);
        end
        // Every combination of the two update gates
        for (i = 0; i < 4; i++) begin
            w = ($urandom & 32'hffff_fff9) | (32'(i) << 1);
            wr(`OFS_CONTROL, w, `RESP_OKAY);
            ctl = w[15:0] & `MASK_CONTROL;
            rd(`OFS_CONTROL, ctl, `RESP_OKAY);
            ev(3'h4, 16'h0);
            chk_clear();
            ev(3'h2, 16'h0);
            chk_clear();
            gen(32'h41);
            chk_clear();
            probe();
        end
        wr(`OFS_PENDING, 32'hffff, `RESP_OKAY);
        rd(`OFS_PENDING, pend, `RESP_OKAY);
        pend = 16'h0;
        repeat (4) begin
            w = $urandom;
            wr(`OFS_ENABLES, w, `RESP_OKAY);
            ena = w[15:0] & `MASK_ENABLES;
            rd(`OFS_ENABLES, ena, `RESP_OKAY);
            ev(3'h1, {4'h0, w[19:16], 4'hf, 4'h0});
            probe();
            rd(`OFS_PENDING, pend, `RESP_OKAY);
            pend = 16'h0;
            probe();
            chk_clear();
        end
        print_verdict();
    end
endmodule

// >>> timer_flags_pkg.sv
// Types shared by the timer flag block
package timer_flags_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic counterOverflow;
        logic triggerReinit;
        logic triggerEvent;
    } timer_events_t;

    typedef struct packed {
        logic [3:0] match;
        logic [3:0] capture;
        logic [3:0] isInput;
        logic [3:0] captureRead;
    } chan_events_t;

    typedef struct packed {
        logic flag;
    } sticky_state_t;

    typedef struct packed {
        logic eventFlag;
        logic overFlag;
    } chan_state_t;

    typedef struct packed {
        bus_state_t writeState;
        bus_state_t readState;
        logic awReady;
        logic wReady;
        logic arReady;
        logic awHeld;
        logic wHeld;
        logic [11:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [15:0] control;
        logic [15:0] enables;
        logic [15:0] pending;
        logic swUpdate;
        logic swTrigger;
        logic updateEvent;
        logic irq;
        logic [3:0] chanIrq;
        logic [3:0] dmaReq;
    } top_state_t;

endpackage

// >>> timer_flags_regs.svh
// Register offsets, bit positions and reset values of the timer flag block
`ifndef TIMER_FLAGS_REGS_SVH
`define TIMER_FLAGS_REGS_SVH

`define OFS_CONTROL 12'h000
`define OFS_ENABLES 12'h00c
`define OFS_FLAGS 12'h010
`define OFS_GENERATE 12'h014
`define OFS_PENDING 12'h01c

`define BIT_UPDATE 0
`define BIT_CH1 1
`define BIT_TRIGGER 6
`define BIT_OVC1 9
`define BIT_UPD_DISABLE 1
`define BIT_UPD_SOURCE 2
`define BIT_DMA_CH1 9
`define BIT_GEN_UPDATE 0
`define BIT_GEN_TRIGGER 6

`define RST_FLAGS 16'h0000
`define RST_CONTROL 16'h0000
`define RST_ENABLES 16'h0000
`define RST_PENDING 16'h0000

`define MASK_FLAGS 16'h1e5f
`define MASK_CONTROL 16'h0006
`define MASK_ENABLES 16'h5f5f
`define MASK_PENDING 16'h005f

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> timer_status_flags.sv
// Timer status flags with AXI4-Lite register access
`timescale 1ns/1ps
`include "timer_flags_regs.svh"
module timer_status_flags
    import timer_flags_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire timer_events_t timerEvents,
    input wire chan_events_t chanEvents,
    output logic updateEvent,
    output logic irq,
    output logic [3:0] channelIrq,
    output logic [3:0] dmaRequest
);

    // ==========================================================
    // State and flag cells
    // ==========================================================
    top_state_t s;
    top_state_t next_s;

    logic updFlag;
    logic trigFlag;
    logic [3:0] chanFlags;
    logic [3:0] overFlags;
    logic [15:0] status;
    logic [15:0] flagClear;
    logic updateNow;
    logic trigNow;
    logic [3:0] chanSet;
    logic ud;
    logic urs;

    assign ud = s.control[`BIT_UPD_DISABLE];
    assign urs = s.control[`BIT_UPD_SOURCE];

    always_comb begin
        updateNow = 1'b0;
        if (!ud) begin
            updateNow = timerEvents.counterOverflow;
            if (!urs) begin
                updateNow = updateNow | s.swUpdate | timerEvents.triggerReinit;
            end
        end
    end

    assign trigNow = timerEvents.triggerEvent | s.swTrigger;
    assign chanSet = (chanEvents.isInput & chanEvents.capture)
        | (~chanEvents.isInput & chanEvents.match);

    sticky_flag u_update_flag (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .setPulse(updateNow),
        .clearPulse(flagClear[`BIT_UPDATE]),
        .flag(updFlag)
    );

    sticky_flag u_trigger_flag (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .setPulse(trigNow),
        .clearPulse(flagClear[`BIT_TRIGGER]),
        .flag(trigFlag)
    );

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            channel_flag u_chan (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .compareMatch(chanEvents.match[ch]),
                .captureEvent(chanEvents.capture[ch]),
                .isInput(chanEvents.isInput[ch]),
                .captureRead(chanEvents.captureRead[ch]),
                .clearEvent(flagClear[`BIT_CH1 + ch]),
                .clearOver(flagClear[`BIT_OVC1 + ch]),
                .eventFlag(chanFlags[ch]),
                .overFlag(overFlags[ch])
            );
        end
    endgenerate

    assign status = {3'b000, overFlags, 2'b00, trigFlag, 1'b0, chanFlags, updFlag};

    // ==========================================================
    // Bus slave and registers
    // ==========================================================
    logic awTake;
    logic wTake;
    logic arTake;
    logic haveAw;
    logic haveW;
    logic doWrite;
    logic [11:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [15:0] laneMask;
    logic [15:0] pendClear;
    logic [15:0] pendSet;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `OFS_CONTROL) || (a == `OFS_ENABLES) || (a == `OFS_FLAGS)
            || (a == `OFS_GENERATE) || (a == `OFS_PENDING);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
        input logic [15:0] m, input logic [15:0] keep);
        merge = ((old & ~m) | (d & m)) & keep;
    endfunction

    always_comb begin
        next_s = s;
        awTake = s_axi_awvalid & s.awReady;
        wTake = s_axi_wvalid & s.wReady;
        arTake = s_axi_arvalid & s.arReady;
        haveAw = s.awHeld | awTake;
        haveW = s.wHeld | wTake;
        wAddr = awTake ? s_axi_awaddr : s.awAddr;
        wData = wTake ? s_axi_wdata : s.wData;
        wStrb = wTake ? s_axi_wstrb : s.wStrb;
        laneMask = {{8{wStrb[1]}}, {8{wStrb[0]}}};
        doWrite = (s.writeState == BUS_IDLE) & haveAw & haveW;
        flagClear = 16'h0000;
        pendClear = 16'h0000;
        next_s.swUpdate = 1'b0;
        next_s.swTrigger = 1'b0;
        next_s.awAddr = wAddr;
        next_s.wData = wData;
        next_s.wStrb = wStrb;
        next_s.awHeld = haveAw;
        next_s.wHeld = haveW;

        // Write channel
        case (s.writeState)
            BUS_IDLE: begin
                if (doWrite) begin
                    next_s.writeState = BUS_RESP;
                    next_s.awHeld = 1'b0;
                    next_s.wHeld = 1'b0;
                    next_s.bValid = 1'b1;
                    next_s.bResp = mapped(wAddr) ? `RESP_OKAY : `RESP_SLVERR;
                    if (wAddr == `OFS_CONTROL) begin
                        next_s.control = merge(s.control, wData[15:0], laneMask,
                            `MASK_CONTROL);
                    end else if (wAddr == `OFS_ENABLES) begin
                        next_s.enables = merge(s.enables, wData[15:0], laneMask,
                            `MASK_ENABLES);
                    end else if (wAddr == `OFS_FLAGS) begin
                        flagClear = laneMask & ~wData[15:0] & `MASK_FLAGS;
                    end else if (wAddr == `OFS_GENERATE) begin
                        next_s.swUpdate = wStrb[0] & wData[`BIT_GEN_UPDATE];
                        next_s.swTrigger = wStrb[0] & wData[`BIT_GEN_TRIGGER];
                    end
                end
            end
            BUS_RESP: begin
                if (s_axi_bready) begin
                    next_s.writeState = BUS_IDLE;
                    next_s.bValid = 1'b0;
                end
            end
            default: begin
                next_s.writeState = BUS_IDLE;
            end
        endcase
        next_s.awReady = (next_s.writeState == BUS_IDLE) & ~next_s.awHeld;
        next_s.wReady = (next_s.writeState == BUS_IDLE) & ~next_s.wHeld;

        // Read channel
        case (s.readState)
            BUS_IDLE: begin
                if (arTake) begin
                    next_s.readState = BUS_RESP;
                    next_s.rValid = 1'b1;
                    next_s.rResp = `RESP_OKAY;
                    next_s.rData = 32'h0000_0000;
                    if (s_axi_araddr == `OFS_CONTROL) begin
                        next_s.rData[15:0] = s.control;
                    end else if (s_axi_araddr == `OFS_ENABLES) begin
                        next_s.rData[15:0] = s.enables;
                    end else if (s_axi_araddr == `OFS_FLAGS) begin
                        next_s.rData[15:0] = status;
                    end else if (s_axi_araddr == `OFS_GENERATE) begin
                        next_s.rData = 32'h0000_0000;
                    end else if (s_axi_araddr == `OFS_PENDING) begin
                        next_s.rData[15:0] = s.pending;
                        pendClear = s.pending;
                    end else begin
                        next_s.rResp = `RESP_SLVERR;
                    end
                end
            end
            BUS_RESP: begin
                if (s_axi_rready) begin
                    next_s.readState = BUS_IDLE;
                    next_s.rValid = 1'b0;
                end
            end
            default: begin
                next_s.readState = BUS_IDLE;
            end
        endcase
        next_s.arReady = next_s.readState == BUS_IDLE;

        // ======================================================
        // Pending events and interrupt outputs
        // ======================================================
        pendSet = {9'h000, trigNow, 1'b0, chanSet, updateNow};
        next_s.pending = ((s.pending & ~pendClear) | pendSet) & `MASK_PENDING;
        next_s.irq = |(next_s.pending & s.enables & `MASK_PENDING);
        next_s.updateEvent = updateNow;
        next_s.chanIrq = chanFlags & s.enables[`BIT_CH1 +: 4];
        next_s.dmaReq = chanFlags & s.enables[`BIT_DMA_CH1 +: 4];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.writeState <= BUS_IDLE;
            s.readState <= BUS_IDLE;
            s.control <= `RST_CONTROL;
            s.enables <= `RST_ENABLES;
            s.pending <= `RST_PENDING;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awReady;
    assign s_axi_wready = s.wReady;
    assign s_axi_bvalid = s.bValid;
    assign s_axi_bresp = s.bResp;
    assign s_axi_arready = s.arReady;
    assign s_axi_rvalid = s.rValid;
    assign s_axi_rdata = s.rData;
    assign s_axi_rresp = s.rResp;
    assign updateEvent = s.updateEvent;
    assign irq = s.irq;
    assign channelIrq = s.chanIrq;
    assign dmaRequest = s.dmaReq;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_sw_update;
        s.swUpdate && !ud && !urs;
    endsequence

    sequence s_flags_zero_write;
        doWrite && wAddr == `OFS_FLAGS && wStrb[0] && !wData[0] && !updateNow;
    endsequence

    property p_overflow_update;
        timerEvents.counterOverflow && !ud |=> updFlag && updateEvent;
    endproperty
    a_overflow_update: assert property (p_overflow_update) else $error("no update");

    property p_disabled_update;
        ud && !updFlag && !flagClear[0] |=> !updFlag;
    endproperty
    a_disabled_update: assert property (p_disabled_update) else $error("update while off");

    property p_sw_update;
        s_sw_update |=> updFlag && updateEvent;
    endproperty
    a_sw_update: assert property (p_sw_update) else $error("sw update lost");

    property p_trig_reinit;
        timerEvents.triggerReinit && !ud && !urs |=> updFlag ##0 updateEvent;
    endproperty
    a_trig_reinit: assert property (p_trig_reinit) else $error("trigger reinit lost");

    property p_update_clear;
        s_flags_zero_write |=> !updFlag;
    endproperty
    a_update_clear: assert property (p_update_clear) else $error("update not cleared");

    property p_match_sets;
        chanEvents.match[0] && !chanEvents.isInput[0] |=> status[`BIT_CH1];
    endproperty
    a_match_sets: assert property (p_match_sets) else $error("match lost");

    property p_ch4_capture;
        chanEvents.capture[3] && chanEvents.isInput[3] |=> status[4];
    endproperty
    a_ch4_capture: assert property (p_ch4_capture) else $error("ch4 capture lost");

    property p_trigger_sets;
        timerEvents.triggerEvent |=> status[`BIT_TRIGGER];
    endproperty
    a_trigger_sets: assert property (p_trigger_sets) else $error("trigger lost");

    property p_ch2_over;
        chanEvents.capture[1] && chanEvents.isInput[1] && chanFlags[1] |=> status[10];
    endproperty
    a_ch2_over: assert property (p_ch2_over) else $error("ch2 overcapture lost");

    property p_reserved_zero;
        (status & ~`MASK_FLAGS) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_status_read;
        arTake && s_axi_araddr == `OFS_FLAGS |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(status);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_chan_irq;
        chanFlags[0] && s.enables[`BIT_CH1] |=> channelIrq[0];
    endproperty
    a_chan_irq: assert property (p_chan_irq) else $error("channel irq missing");

    property p_chan_dma;
        chanFlags[2] && s.enables[`BIT_DMA_CH1 + 2] |=> dmaRequest[2];
    endproperty
    a_chan_dma: assert property (p_chan_dma) else $error("channel dma missing");

endmodule
